//--- core/uecm_defs.vh
`ifndef UECM_DEFS_VH
`define UECM_DEFS_VH

// Register indices; the byte address is four times the index.
`define UECM_IDX_ENDPOINT0_COUNT       8'h41
`define UECM_IDX_ENDPOINT1_COUNT       8'h43
`define UECM_IDX_ENDPOINT0_MODE_STATUS 8'h44
`define UECM_IDX_ENDPOINT2_COUNT       8'h45
`define UECM_IDX_INT_STATUS            8'h48
`define UECM_IDX_INT_MASK              8'h49

// Count register fields.
`define UECM_CNT_TOGGLE_BIT            7
`define UECM_CNT_VALID_BIT             6
`define UECM_CNT_CRC_BYTES             4'h2

// Mode/status register fields.
`define UECM_MODE_SETUP_BIT            7
`define UECM_MODE_IN_BIT               6
`define UECM_MODE_OUT_BIT              5
`define UECM_MODE_ACK_BIT              4

// Interrupt status bit positions.
`define UECM_INT_SETUP                 0
`define UECM_INT_IN                    1
`define UECM_INT_OUT                   2
`define UECM_INT_ACK                   3
`define UECM_INT_EP1_RX                4
`define UECM_INT_EP2_RX                5
`define UECM_INT_REFUSED               6

// Transaction kinds reported by the protocol engine.
`define UECM_KIND_OUT                  2'h0
`define UECM_KIND_IN                   2'h1
`define UECM_KIND_SETUP                2'h2

// Reset values and bus responses.
`define UECM_RST_REG                   8'h00
`define UECM_RESP_OKAY                 2'h0
`define UECM_RESP_SLVERR               2'h2

`endif

//--- core/uecm_count_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "uecm_defs.vh"

module uecm_count_reg #(
   parameter LOCKABLE = 1
) (
   input  wire       mclk,       // System clock.
   input  wire       resetn,     // Synchronous reset, active low.
   input  wire       cpu_wr,     // Processor write pulse.
   input  wire       cpu_rd,     // Processor read pulse.
   input  wire [7:0] cpu_wdata,  // Processor write data.
   input  wire       pe_wr,      // Engine update pulse after OUT/SETUP data.
   input  wire       pe_toggle,  // Received data toggle.
   input  wire       pe_good,    // Received data had no error.
   input  wire [3:0] pe_len,     // Received data bytes.
   output reg  [7:0] value,      // Register contents.
   output wire       refused     // Processor write dropped this cycle.
);

   reg        locked;
   wire [3:0] rx_total;

   assign rx_total = pe_len + `UECM_CNT_CRC_BYTES;
   // The engine has priority, so a write colliding with an update is lost too.
   assign refused  = cpu_wr & (locked | pe_wr);

   // Engine updates win over processor writes; firmware reads clear the lock.
   always @(posedge mclk) begin
      if (!resetn) begin
         value  <= `UECM_RST_REG;
         locked <= 1'b0;
      end else if (pe_wr) begin
         value  <= {pe_toggle, pe_good, 2'b00, rx_total};
         locked <= (LOCKABLE != 0);
      end else begin
         if (cpu_wr && !locked) begin
            value <= cpu_wdata;
         end
         if (cpu_rd) begin
            locked <= 1'b0;
         end
      end
   end

endmodule // uecm_count_reg
`default_nettype wire

//--- core/uecm_axil_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "uecm_defs.vh"

module uecm_axil_slave #(
   parameter AW = 12
) (
   input  wire          mclk,          // System clock.
   input  wire          resetn,        // Synchronous reset, active low.
   input  wire [AW-1:0] s_axi_awaddr,  // Write address.
   input  wire          s_axi_awvalid, // Write address valid.
   output reg           s_axi_awready, // Write address ready.
   input  wire [31:0]   s_axi_wdata,   // Write data.
   input  wire [3:0]    s_axi_wstrb,   // Write strobes.
   input  wire          s_axi_wvalid,  // Write data valid.
   output reg           s_axi_wready,  // Write data ready.
   output reg  [1:0]    s_axi_bresp,   // Write response.
   output reg           s_axi_bvalid,  // Write response valid.
   input  wire          s_axi_bready,  // Write response ready.
   input  wire [AW-1:0] s_axi_araddr,  // Read address.
   input  wire          s_axi_arvalid, // Read address valid.
   output reg           s_axi_arready, // Read address ready.
   output reg  [31:0]   s_axi_rdata,   // Read data.
   output reg  [1:0]    s_axi_rresp,   // Read response.
   output reg           s_axi_rvalid,  // Read data valid.
   input  wire          s_axi_rready,  // Read data ready.
   output wire          wr_en,         // One-cycle register write.
   output wire [7:0]    wr_idx,        // Register index of the write.
   output wire [7:0]    wr_data,       // Low byte of write data.
   input  wire          wr_hit,        // Write index is mapped.
   output wire          rd_en,         // One-cycle register read.
   output wire [7:0]    rd_idx,        // Register index of the read.
   input  wire [7:0]    rd_data,       // Read value for rd_idx.
   input  wire          rd_hit         // Read index is mapped.
);

   reg [AW-1:0] aw_addr;
   reg [7:0]    w_data;
   reg          w_lane0;

   // Address and data are held until both arrived; ready low means held.
   assign wr_en   = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;
   assign wr_idx  = aw_addr[9:2];
   assign wr_data = w_lane0 ? w_data : 8'h00;
   assign rd_en   = s_axi_arvalid & s_axi_arready;
   assign rd_idx  = s_axi_araddr[9:2];

   // Write channel; a write without byte lane zero stores zero.
   always @(posedge mclk) begin
      if (!resetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `UECM_RESP_OKAY;
         aw_addr       <= {AW{1'b0}};
         w_data        <= 8'h00;
         w_lane0       <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
         end
         if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `UECM_RESP_OKAY : `UECM_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Read channel; data is captured at the address handshake.
   always @(posedge mclk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `UECM_RESP_OKAY;
      end else if (rd_en) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_data};
         s_axi_rresp   <= rd_hit ? `UECM_RESP_OKAY : `UECM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule // uecm_axil_slave
`default_nettype wire

//--- core/uecm_top.v
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uecm_defs.vh"

module uecm_top #(
   parameter AW = 12
) (
   input  wire          mclk,            // System clock, 40 MHz.
   input  wire          resetn,          // Synchronous reset, active low.
   // Register bus.
   input  wire [AW-1:0] s_axi_awaddr,    // Write address.
   input  wire          s_axi_awvalid,   // Write address valid.
   output wire          s_axi_awready,   // Write address ready.
   input  wire [31:0]   s_axi_wdata,     // Write data.
   input  wire [3:0]    s_axi_wstrb,     // Write strobes.
   input  wire          s_axi_wvalid,    // Write data valid.
   output wire          s_axi_wready,    // Write data ready.
   output wire [1:0]    s_axi_bresp,     // Write response.
   output wire          s_axi_bvalid,    // Write response valid.
   input  wire          s_axi_bready,    // Write response ready.
   input  wire [AW-1:0] s_axi_araddr,    // Read address.
   input  wire          s_axi_arvalid,   // Read address valid.
   output wire          s_axi_arready,   // Read address ready.
   output wire [31:0]   s_axi_rdata,     // Read data.
   output wire [1:0]    s_axi_rresp,     // Read response.
   output wire          s_axi_rvalid,    // Read data valid.
   input  wire          s_axi_rready,    // Read data ready.
   // Protocol engine side, same clock.
   input  wire [1:0]    pe_ep,           // Endpoint of the current event.
   input  wire          pe_rx_done,      // OUT/SETUP data packet finished.
   input  wire          pe_rx_setup,     // Finished packet was SETUP data.
   input  wire          pe_rx_toggle,    // Received data toggle.
   input  wire          pe_rx_good,      // No CRC, stuffing or PID error.
   input  wire [3:0]    pe_rx_len,       // Received data bytes, zero to eight.
   input  wire          pe_txn_ack,      // Transaction ended with ACK.
   input  wire [1:0]    pe_txn_kind,     // Kind of the acknowledged transaction.
   input  wire          pe_ctrl_wr_end,  // Control write data phase ended.
   input  wire          pe_mode_wr,      // Engine writes the control mode field.
   input  wire [3:0]    pe_mode_data,    // Mode value from the engine.
   output wire [2:0]    tx_toggle,       // Toggle to send per endpoint.
   output wire [11:0]   tx_count,        // IN byte count per endpoint.
   output wire [3:0]    ctrl_mode,       // Control endpoint mode field.
   output wire          ctrl_buf_wr_block, // Data buffer writes blocked.
   output reg           irq              // Level interrupt.
);

   localparam NEP = 3;

   wire         wr_en;
   wire [7:0]   wr_idx;
   wire [7:0]   wr_data;
   reg          wr_hit;
   wire         rd_en;
   wire [7:0]   rd_idx;
   reg  [7:0]   rd_data;
   reg          rd_hit;

   wire [7:0]   cnt_val  [0:NEP-1];
   wire [NEP-1:0] cnt_refused;
   wire [NEP-1:0] cnt_pe_wr;

   reg  [3:0]   mode;
   reg          flag_setup;
   reg          flag_in;
   reg          flag_out;
   reg          flag_ack;
   reg          mode_locked;
   reg          setup_hold;
   reg  [7:0]   int_status;
   reg  [7:0]   int_mask;

   wire         is_ctrl;
   wire         setup_evt;
   wire         in_evt;
   wire         out_evt;
   wire         ack_evt;
   wire         flag_evt;
   wire         mode_wr_req;
   wire         mode_wr_ok;
   wire         mode_refused;
   wire         mode_rd;
   wire [7:0]   mode_reg;
   wire [7:0]   next_int_status;
   wire [7:0]   int_events;

   uecm_axil_slave #(
      .AW (AW)
   ) u_bus (
      .mclk          (mclk),
      .resetn        (resetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_idx        (wr_idx),
      .wr_data       (wr_data),
      .wr_hit        (wr_hit),
      .rd_en         (rd_en),
      .rd_idx        (rd_idx),
      .rd_data       (rd_data),
      .rd_hit        (rd_hit)
   );

   // One count register per endpoint; only the control endpoint has a lock.
   genvar gi;
   generate
      for (gi = 0; gi < NEP; gi = gi + 1) begin : g_cnt
         // The index is a constant per endpoint; a process with no inputs would never run.
         localparam [7:0] CIDX = (gi == 0) ? `UECM_IDX_ENDPOINT0_COUNT :
                                 (gi == 1) ? `UECM_IDX_ENDPOINT1_COUNT : `UECM_IDX_ENDPOINT2_COUNT;
         assign cnt_pe_wr[gi] = pe_rx_done & (pe_ep == gi);
         uecm_count_reg #(
            .LOCKABLE ((gi == 0) ? 1 : 0)
         ) u_cnt (
            .mclk      (mclk),
            .resetn    (resetn),
            .cpu_wr    (wr_en & (wr_idx == CIDX)),
            .cpu_rd    (rd_en & (rd_idx == CIDX)),
            .cpu_wdata (wr_data),
            .pe_wr     (cnt_pe_wr[gi]),
            .pe_toggle (pe_rx_toggle),
            .pe_good   (pe_rx_good),
            .pe_len    (pe_rx_len),
            .value     (cnt_val[gi]),
            .refused   (cnt_refused[gi])
         );
         // The engine reads the firmware toggle and count for IN data.
         assign tx_toggle[gi]        = cnt_val[gi][`UECM_CNT_TOGGLE_BIT];
         assign tx_count[4*gi+3:4*gi] = cnt_val[gi][3:0];
      end
   endgenerate

   // Control endpoint events decoded from the engine's report.
   assign is_ctrl   = (pe_ep == 2'h0);
   assign setup_evt = is_ctrl & pe_rx_done & pe_rx_setup & pe_rx_good;
   assign in_evt    = is_ctrl & pe_txn_ack & (pe_txn_kind == `UECM_KIND_IN);
   assign out_evt   = is_ctrl & pe_txn_ack & (pe_txn_kind == `UECM_KIND_OUT);
   assign ack_evt   = is_ctrl & pe_txn_ack;
   assign flag_evt  = setup_evt | in_evt | out_evt | ack_evt;

   // A processor write only lands while unlocked and without an engine update.
   assign mode_wr_req  = wr_en & (wr_idx == `UECM_IDX_ENDPOINT0_MODE_STATUS);
   assign mode_wr_ok   = mode_wr_req & !mode_locked & !pe_mode_wr & !flag_evt;
   assign mode_refused = mode_wr_req & !mode_wr_ok;
   assign mode_rd      = rd_en & (rd_idx == `UECM_IDX_ENDPOINT0_MODE_STATUS);
   assign mode_reg     = {flag_setup, flag_in, flag_out, flag_ack, mode};

   // Lock follows any engine update; firmware releases it by reading.
   always @(posedge mclk) begin
      if (!resetn) begin
         mode_locked <= 1'b0;
      end else if (pe_mode_wr || flag_evt) begin
         mode_locked <= 1'b1;
      end else if (mode_rd) begin
         mode_locked <= 1'b0;
      end
   end

   // Mode field: engine value wins, else an accepted firmware write.
   always @(posedge mclk) begin
      if (!resetn) begin
         mode <= 4'h0;
      end else if (pe_mode_wr) begin
         mode <= pe_mode_data;
      end else if (mode_wr_ok) begin
         mode <= wr_data[3:0];
      end
   end

   // The setup flag may not be dropped until the control write data phase ends.
   always @(posedge mclk) begin
      if (!resetn) begin
         setup_hold <= 1'b0;
      end else if (setup_evt) begin
         setup_hold <= 1'b1;
      end else if (pe_ctrl_wr_end) begin
         setup_hold <= 1'b0;
      end
   end

   // Status flags: hardware set wins over the write clear in the same cycle.
   always @(posedge mclk) begin
      if (!resetn) begin
         flag_setup <= 1'b0;
         flag_in    <= 1'b0;
         flag_out   <= 1'b0;
         flag_ack   <= 1'b0;
      end else begin
         if (setup_evt) begin
            flag_setup <= 1'b1;
         end else if (mode_wr_ok && !setup_hold) begin
            flag_setup <= 1'b0;
         end
         if (in_evt) begin
            flag_in <= 1'b1;
         end else if (mode_wr_ok) begin
            flag_in <= 1'b0;
         end
         if (out_evt) begin
            flag_out <= 1'b1;
         end else if (mode_wr_ok) begin
            flag_out <= 1'b0;
         end
         if (ack_evt) begin
            flag_ack <= 1'b1;
         end else if (mode_wr_ok) begin
            flag_ack <= 1'b0;
         end
      end
   end

   // The data buffer owner sees the guard straight from the setup flag.
   assign ctrl_buf_wr_block = flag_setup;
   assign ctrl_mode         = mode;

   // Interrupt sources; the refused bit tells firmware to read and retry.
   assign int_events[`UECM_INT_SETUP]   = setup_evt;
   assign int_events[`UECM_INT_IN]      = in_evt;
   assign int_events[`UECM_INT_OUT]     = out_evt;
   assign int_events[`UECM_INT_ACK]     = ack_evt;
   assign int_events[`UECM_INT_EP1_RX]  = cnt_pe_wr[1];
   assign int_events[`UECM_INT_EP2_RX]  = cnt_pe_wr[2];
   assign int_events[`UECM_INT_REFUSED] = mode_refused | cnt_refused[0];
   assign int_events[7]                 = 1'b0;

   // Write one to clear; a new event in the same cycle keeps its bit set.
   assign next_int_status = (int_status &
                             ~((wr_en && wr_idx == `UECM_IDX_INT_STATUS) ? wr_data : 8'h00))
                            | int_events;

   always @(posedge mclk) begin
      if (!resetn) begin
         int_status <= 8'h00;
         int_mask   <= 8'h00;
         irq        <= 1'b0;
      end else begin
         int_status <= next_int_status;
         if (wr_en && wr_idx == `UECM_IDX_INT_MASK) begin
            int_mask <= wr_data;
         end
         irq <= |(next_int_status & int_mask);
      end
   end

   // Write decode; unmapped indices answer with a slave error.
   always @* begin
      case (wr_idx)
         `UECM_IDX_ENDPOINT0_COUNT,
         `UECM_IDX_ENDPOINT1_COUNT,
         `UECM_IDX_ENDPOINT0_MODE_STATUS,
         `UECM_IDX_ENDPOINT2_COUNT,
         `UECM_IDX_INT_STATUS,
         `UECM_IDX_INT_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Read mux; unmapped indices read zero with a slave error.
   always @* begin
      rd_hit = 1'b1;
      case (rd_idx)
         `UECM_IDX_ENDPOINT0_COUNT:       rd_data = cnt_val[0];
         `UECM_IDX_ENDPOINT1_COUNT:       rd_data = cnt_val[1];
         `UECM_IDX_ENDPOINT0_MODE_STATUS: rd_data = mode_reg;
         `UECM_IDX_ENDPOINT2_COUNT:       rd_data = cnt_val[2];
         `UECM_IDX_INT_STATUS:            rd_data = int_status;
         `UECM_IDX_INT_MASK:              rd_data = int_mask;
         default: begin
            rd_data = 8'h00;
            rd_hit  = 1'b0;
         end
      endcase
   end

endmodule // uecm_top
`default_nettype wire

//--- verification/uecm_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module uecm_top_chk #(
   parameter AW = 12
) (
   input wire logic        mclk,              // Clock.
   input wire logic        resetn,            // Reset, active low.
   input wire logic        s_axi_bvalid,      // Write response valid.
   input wire logic [1:0]  pe_ep,             // Event endpoint.
   input wire logic        pe_rx_done,        // Data packet done.
   input wire logic        pe_rx_setup,       // Packet was SETUP data.
   input wire logic        pe_rx_toggle,      // Received toggle.
   input wire logic        pe_rx_good,        // Packet good.
   input wire logic [3:0]  pe_rx_len,         // Received bytes.
   input wire logic        pe_ctrl_wr_end,    // Data phase over.
   input wire logic        pe_mode_wr,        // Engine mode write.
   input wire logic [3:0]  pe_mode_data,      // Engine mode value.
   input wire logic [2:0]  tx_toggle,         // Toggles.
   input wire logic [11:0] tx_count,          // Counts.
   input wire logic [3:0]  ctrl_mode,         // Mode field.
   input wire logic        ctrl_buf_wr_block, // Buffer block.
   input wire logic        irq                // Interrupt.
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic hold;
   wire  setup_ev = pe_rx_done && pe_rx_setup && pe_rx_good && pe_ep == 2'h0;
   // The setup flag may not fall until the control write data phase is over.
   always @(posedge mclk) begin
      if (!resetn) hold <= 1'b0;
      else if (setup_ev) hold <= 1'b1;
      else if (pe_ctrl_wr_end) hold <= 1'b0;
   end
   AST_RESET: assert property (disable iff (1'b0) !resetn |=> tx_count == 12'h000 && tx_toggle == 3'h0
      && ctrl_mode == 4'h0 && !ctrl_buf_wr_block && !irq) else $error("state not cleared by reset");
   AST_TOG0: assert property (pe_rx_done && pe_ep == 2'h0 |=> tx_toggle[0] == $past(pe_rx_toggle))
      else $error("toggle of endpoint 0 not loaded");
   AST_TOG2: assert property (pe_rx_done && pe_ep == 2'h2 |=> tx_toggle[2] == $past(pe_rx_toggle))
      else $error("toggle of endpoint 2 not loaded");
   AST_CNT1: assert property (pe_rx_done && pe_ep == 2'h1 |=> tx_count[7:4] == $past(pe_rx_len) + 4'h2)
      else $error("count of endpoint 1 not len plus two");
   AST_BLOCK: assert property (setup_ev |-> ##[1:2] ctrl_buf_wr_block)
      else $error("buffer not blocked after setup");
   AST_HOLD: assert property (hold |=> ctrl_buf_wr_block)
      else $error("setup flag fell during data phase");
   AST_MODE: assert property (pe_mode_wr |=> ctrl_mode == $past(pe_mode_data))
      else $error("engine mode write lost");
   AST_CAUSE: assert property ($past(resetn) && $changed(ctrl_mode) |-> $past(pe_mode_wr) || $rose(s_axi_bvalid))
      else $error("mode changed without a writer");
   cover property (setup_ev);
   cover property (pe_mode_wr);
   cover property ($rose(irq));
endmodule // uecm_top_chk
bind uecm_top uecm_top_chk #(.AW(AW)) u_chk (.mclk(mclk), .resetn(resetn), .s_axi_bvalid(s_axi_bvalid),
   .pe_ep(pe_ep), .pe_rx_done(pe_rx_done), .pe_rx_setup(pe_rx_setup), .pe_rx_toggle(pe_rx_toggle),
   .pe_rx_good(pe_rx_good), .pe_rx_len(pe_rx_len), .pe_ctrl_wr_end(pe_ctrl_wr_end), .pe_mode_wr(pe_mode_wr),
   .pe_mode_data(pe_mode_data), .tx_toggle(tx_toggle), .tx_count(tx_count), .ctrl_mode(ctrl_mode),
   .ctrl_buf_wr_block(ctrl_buf_wr_block), .irq(irq));
`default_nettype wire

//--- verification/uecm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module uecm_host_model (
   input  wire logic       mclk,      // Clock.
   output var  logic [1:0] ep,        // Endpoint.
   output var  logic       done,      // Data packet done.
   output var  logic       setup,     // SETUP data.
   output var  logic       tog,       // Toggle.
   output var  logic       good,      // No error.
   output var  logic [3:0] len,       // Bytes.
   output var  logic       ack,       // ACK seen.
   output var  logic [1:0] kind,      // Transaction kind.
   output var  logic       wend,      // Data phase over.
   output var  logic       mwr,       // Mode write.
   output var  logic [3:0] mdata      // Mode value.
);
   initial {ep, done, setup, tog, good, len, ack, kind, wend, mwr, mdata} = 0;
   // Qualifiers are inverted after each pulse so nothing leans on stale values.
   task automatic rx(input [1:0] e, input s, input t, input g, input [3:0] l);
      @(posedge mclk);
      {ep, setup, tog, good, len, done} <= {e, s, t, g, l, 1'b1};
      @(posedge mclk);
      {ep, setup, tog, good, len, done} <= {~e, ~s, ~t, ~g, ~l, 1'b0};
   endtask
   task automatic hs(input [1:0] e, input [1:0] k);
      @(posedge mclk);
      {ep, kind, ack} <= {e, k, 1'b1};
      @(posedge mclk);
      {ep, kind, ack} <= {~e, ~k, 1'b0};
   endtask
   task automatic mode(input [3:0] d);
      @(posedge mclk);
      {mdata, mwr} <= {d, 1'b1};
      @(posedge mclk);
      {mdata, mwr} <= {~d, 1'b0};
   endtask
   task automatic phase_end();
      @(posedge mclk);
      wend <= 1'b1;
      @(posedge mclk);
      wend <= 1'b0;
   endtask
endmodule // uecm_host_model
`default_nettype wire

//--- verification/tb_usb_endpoint_count_mode_interlock.sv
`timescale 1ns/1ps
`default_nettype none
`include "uecm_defs.vh"
module tb_usb_endpoint_count_mode_interlock;
   localparam [7:0] C0 = `UECM_IDX_ENDPOINT0_COUNT, C1 = `UECM_IDX_ENDPOINT1_COUNT, C2 = `UECM_IDX_ENDPOINT2_COUNT;
   localparam [7:0] MD = `UECM_IDX_ENDPOINT0_MODE_STATUS, IS = `UECM_IDX_INT_STATUS, IM = `UECM_IDX_INT_MASK;
   logic        mclk = 0, resetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0;
   wire         awr, wr_r, bv, arr, rv, irq, blk, done, setup, tog, good, ack, wend, mwr;
   wire [1:0]   bresp, rresp, ep, kind;
   wire [31:0]  rdata;
   wire [3:0]   len, mdata, cmode;
   wire [2:0]   txt;
   wire [11:0]  txc;
   int          failures = 0, n_tests = 0, cyc = 0;
   uecm_top #(.AW(12)) uut (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .pe_ep(ep), .pe_rx_done(done), .pe_rx_setup(setup), .pe_rx_toggle(tog), .pe_rx_good(good),
      .pe_rx_len(len), .pe_txn_ack(ack), .pe_txn_kind(kind), .pe_ctrl_wr_end(wend), .pe_mode_wr(mwr),
      .pe_mode_data(mdata), .tx_toggle(txt), .tx_count(txc), .ctrl_mode(cmode), .ctrl_buf_wr_block(blk), .irq(irq));
   uecm_host_model host (.mclk(mclk), .ep(ep), .done(done), .setup(setup), .tog(tog), .good(good), .len(len),
      .ack(ack), .kind(kind), .wend(wend), .mwr(mwr), .mdata(mdata));
   always #12.5 mclk = ~mclk;
   task automatic chk(input bit ok);
      n_tests++;
      if (!ok) begin
         failures++;
         $display("Error %0t: unexpected value", $time);
      end
   endtask
   // Address and data go out together; each is dropped once taken.
   task automatic wr(input [7:0] i, input [7:0] d);
      @(posedge mclk);
      {awa, wd, awv, wv, br} <= {2'h0, i, 2'h0, 24'h0, d, 3'h7};
      do begin
         @(posedge mclk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end while (!bv);
      br <= 1'b0;
      chk(bresp === `UECM_RESP_OKAY);
   endtask
   task automatic rd(input [7:0] i, input [7:0] e, input [1:0] r);
      @(posedge mclk);
      {ara, arv, rr} <= {2'h0, i, 2'h0, 2'h3};
      do begin
         @(posedge mclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rr <= 1'b0;
      chk(rdata === {24'h0, e} && rresp === r);
   endtask
   task automatic t_reset();
      rd(C0, 8'h00, 0); rd(C1, 8'h00, 0); rd(C2, 8'h00, 0); rd(MD, 8'h00, 0);
      chk(txc === 12'h000 && cmode === 4'h0 && irq === 1'b0);
   endtask
   task automatic t_count();
      host.rx(0, 0, 1, 1, 3); wr(C0, 8'h08); rd(C0, 8'hC5, 0);
      chk(txt[0] === 1'b1 && txc[3:0] === 4'h5);
      wr(C0, 8'h08); rd(C0, 8'h08, 0); chk(txc[3:0] === 4'h8 && txt[0] === 1'b0);
      host.rx(1, 0, 0, 0, 8); rd(C1, 8'h0A, 0);
      host.rx(2, 0, 1, 1, 0); rd(C2, 8'hC2, 0); chk(txt[2] === 1'b1);
   endtask
   task automatic t_in();
      wr(IS, 8'h7F); wr(IM, 8'h02); host.hs(0, `UECM_KIND_IN);
      repeat (2) @(posedge mclk);
      chk(irq === 1'b1);
      wr(MD, 8'h0F); rd(MD, 8'h50, 0);
      rd(IS, 8'h4A, 0);
      wr(MD, 8'hF3); rd(MD, 8'h03, 0);
      wr(IS, 8'h02);
      repeat (2) @(posedge mclk);
      chk(irq === 1'b0);
   endtask
   task automatic t_setup();
      host.rx(0, 1, 0, 1, 8);
      repeat (2) @(posedge mclk);
      chk(blk === 1'b1);
      wr(MD, 8'h05); rd(MD, 8'h83, 0); rd(C0, 8'h4A, 0);
      wr(MD, 8'h05); rd(MD, 8'h85, 0); chk(blk === 1'b1);
      host.phase_end(); wr(MD, 8'h05); rd(MD, 8'h05, 0); chk(blk === 1'b0);
      host.hs(0, `UECM_KIND_OUT); rd(MD, 8'h35, 0);
   endtask
   task automatic t_mode();
      host.mode(4'h9);
      @(posedge mclk);
      chk(cmode === 4'h9);
      wr(MD, 8'h02); rd(MD, 8'h39, 0);
      wr(MD, 8'h02); rd(MD, 8'h02, 0); chk(cmode === 4'h2);
      rd(8'h4F, 8'h00, `UECM_RESP_SLVERR);
   endtask
   task automatic summarize();
      if (failures == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // A hang is cut short well beyond the hundred and fifty or so cycles the run needs.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      t_reset(); t_count(); t_in(); t_setup(); t_mode();
      // A second reset in mid-run must clear what the scenarios left behind.
      @(posedge mclk) resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      summarize();
   end
endmodule // tb_usb_endpoint_count_mode_interlock
`default_nettype wire
